// ==== rtl/pdbmc_codec.sv ====
// Baseband biphase mark codec top: encoder, pin steering and receiver.
// Assumes a message engine on ref_clk_in and an orientation strap from attach logic.
// Functional notes
// - Invert line at every bit boundary.
// - Ones add mid-bit inversion; zeros do not.
// - Keep disparity within half a bit.
// - Preamble starts with a driven low.
// - Receiver tolerates missing first preamble edge.
// - Closing edge after last bit, then release.
// - Drive only while sending; else high impedance.
// - Use only orientation-selected pin.
// - Only one party drives shared line.
`timescale 1ns/1ns
module pdbmc_codec #(
	parameter int unsigned CNT_W = pdbmc_pkg::CNT_W,
	parameter logic [pdbmc_pkg::CNT_W-1:0] HALF_DEF = pdbmc_pkg::HALF_DEF
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [CNT_W-1:0] half_cycles_in,
	input wire logic orient_b_in,
	input wire logic tx_start_in,
	input wire logic tx_bit_in,
	input wire logic tx_last_in,
	output logic tx_bit_req_out,
	output logic tx_busy_out,
	input wire logic config_channel_pin_a_in,
	output logic config_channel_pin_a_out,
	output logic config_channel_pin_a_oe_out,
	input wire logic config_channel_pin_b_in,
	output logic config_channel_pin_b_out,
	output logic config_channel_pin_b_oe_out,
	output logic rx_bit_valid_out,
	output logic rx_bit_out,
	output logic rx_busy_out
);
	pdbmc_pkg::pdbmc_tx_state_t st_r, st_nxt;
	logic [CNT_W-1:0] div_r, div_nxt, half_r, half_nxt;
	logic phase_r, phase_nxt;
	logic lvl_r, lvl_nxt;
	logic cur_r, cur_nxt, cur_last_r, cur_last_nxt;
	logic nb_r, nb_nxt, nb_last_r, nb_last_nxt;
	logic req_r, req_nxt;
	logic oe_a_r, oe_a_nxt, oe_b_r, oe_b_nxt;
	logic out_r, out_nxt;
	logic orient_r, orient_nxt;
	logic busy_r, busy_nxt;
	logic [1:0] sa_r, sb_r;
	logic rx_line;
	logic tick;

	// Pin inputs pass two flops before use
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			// Reset to the idle bias level of the line
			sa_r <= 2'b11;
			sb_r <= 2'b11;
		end else begin
			sa_r <= {sa_r[0], config_channel_pin_a_in};
			sb_r <= {sb_r[0], config_channel_pin_b_in};
		end
	end

	assign rx_line = orient_r ? sb_r[1] : sa_r[1];
	assign tick = (div_r == CNT_W'(1));

	always_comb begin
		st_nxt = st_r;
		div_nxt = div_r;
		half_nxt = half_r;
		phase_nxt = phase_r;
		lvl_nxt = lvl_r;
		cur_nxt = cur_r;
		cur_last_nxt = cur_last_r;
		nb_nxt = nb_r;
		nb_last_nxt = nb_last_r;
		req_nxt = 1'b0;
		orient_nxt = orient_r;
		// Half-bit divider enable
		if (st_r != pdbmc_pkg::PDBMC_TX_IDLE) begin
			div_nxt = tick ? half_r : CNT_W'(div_r - CNT_W'(1));
		end
		// Bit requested one bit period before it is sent; the first bit half a bit before, at the preamble start
		if (req_r) begin
			nb_nxt = tx_bit_in;
			nb_last_nxt = tx_last_in;
		end
		unique case (st_r)
			pdbmc_pkg::PDBMC_TX_IDLE: begin
				// Follow orientation while idle so the receiver watches the live pin
				orient_nxt = orient_b_in;
				if (tx_start_in && !rx_busy_out) begin
					st_nxt = pdbmc_pkg::PDBMC_TX_PRE;
					half_nxt = (half_cycles_in == CNT_W'(0)) ? HALF_DEF : half_cycles_in;
					div_nxt = (half_cycles_in == CNT_W'(0)) ? HALF_DEF : half_cycles_in;
					orient_nxt = orient_b_in;
					lvl_nxt = 1'b0;
					phase_nxt = 1'b0;
					req_nxt = 1'b1;
				end
			end
			pdbmc_pkg::PDBMC_TX_PRE: begin
				// One low half bit, then the first bit boundary
				if (tick) begin
					st_nxt = pdbmc_pkg::PDBMC_TX_BIT;
					lvl_nxt = ~lvl_r;
					cur_nxt = nb_r;
					cur_last_nxt = nb_last_r;
					phase_nxt = 1'b1;
					req_nxt = !nb_last_r;
				end
			end
			pdbmc_pkg::PDBMC_TX_BIT: begin
				if (tick) begin
					if (phase_r) begin
						// Mid-bit: ones toggle, which bounds disparity to half a bit
						if (cur_r) begin
							lvl_nxt = ~lvl_r;
						end
						phase_nxt = 1'b0;
					end else begin
						lvl_nxt = ~lvl_r;
						if (cur_last_r) begin
							st_nxt = pdbmc_pkg::PDBMC_TX_CLOSE;
						end else begin
							cur_nxt = nb_r;
							cur_last_nxt = nb_last_r;
							phase_nxt = 1'b1;
							req_nxt = !nb_last_r;
						end
					end
				end
			end
			pdbmc_pkg::PDBMC_TX_CLOSE: begin
				// Hold the closing edge a half bit, then release
				if (tick) begin
					st_nxt = pdbmc_pkg::PDBMC_TX_IDLE;
				end
			end
		endcase
		out_nxt = lvl_nxt;
		oe_a_nxt = (st_nxt != pdbmc_pkg::PDBMC_TX_IDLE) && !orient_nxt;
		oe_b_nxt = (st_nxt != pdbmc_pkg::PDBMC_TX_IDLE) && orient_nxt;
		busy_nxt = (st_nxt != pdbmc_pkg::PDBMC_TX_IDLE);
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			st_r <= pdbmc_pkg::PDBMC_TX_IDLE;
			div_r <= HALF_DEF;
			half_r <= HALF_DEF;
			phase_r <= 1'b0;
			lvl_r <= 1'b0;
			cur_r <= 1'b0;
			cur_last_r <= 1'b0;
			nb_r <= 1'b0;
			nb_last_r <= 1'b0;
			req_r <= 1'b0;
			oe_a_r <= 1'b0;
			oe_b_r <= 1'b0;
			out_r <= 1'b0;
			orient_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			half_r <= half_nxt;
			phase_r <= phase_nxt;
			lvl_r <= lvl_nxt;
			cur_r <= cur_nxt;
			cur_last_r <= cur_last_nxt;
			nb_r <= nb_nxt;
			nb_last_r <= nb_last_nxt;
			req_r <= req_nxt;
			oe_a_r <= oe_a_nxt;
			oe_b_r <= oe_b_nxt;
			out_r <= out_nxt;
			orient_r <= orient_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign config_channel_pin_a_out = out_r;
	assign config_channel_pin_b_out = out_r;
	assign config_channel_pin_a_oe_out = oe_a_r;
	assign config_channel_pin_b_oe_out = oe_b_r;
	assign tx_bit_req_out = req_r;
	assign tx_busy_out = busy_r;

	// Receiver sees only the selected pin and is blind while we transmit
	pdbmc_rx #(
		.CNT_W(CNT_W)
	) u_rx (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.line_in(rx_line),
		.enable_in(st_r == pdbmc_pkg::PDBMC_TX_IDLE),
		.half_cycles_in((half_cycles_in == CNT_W'(0)) ? HALF_DEF : half_cycles_in),
		.bit_valid_out(rx_bit_valid_out),
		.bit_out(rx_bit_out),
		.busy_out(rx_busy_out)
	);

	chk_one_pin_only: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) !(oe_a_r && oe_b_r))
		else $error("both pins driven");
	chk_idle_hiz: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) st_r == pdbmc_pkg::PDBMC_TX_IDLE |-> !oe_a_r && !oe_b_r)
		else $error("driver enabled while idle");
	chk_busy_state_flop: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) tx_busy_out == (st_r != pdbmc_pkg::PDBMC_TX_IDLE))
		else $error("busy flag out of step with state");
	chk_preamble_low: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) $rose(tx_busy_out) |-> !out_r)
		else $error("preamble did not start low");
	chk_bound_edge: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		st_r == pdbmc_pkg::PDBMC_TX_BIT && tick && !phase_r |=> lvl_r != $past(lvl_r))
		else $error("missing bit boundary edge");
	chk_zero_no_mid: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		st_r == pdbmc_pkg::PDBMC_TX_BIT && tick && phase_r && !cur_r |=> $stable(lvl_r))
		else $error("zero bit toggled mid period");
	chk_close_edge: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		st_r == pdbmc_pkg::PDBMC_TX_BIT && $past(st_r) == pdbmc_pkg::PDBMC_TX_BIT
		&& st_nxt == pdbmc_pkg::PDBMC_TX_CLOSE |=> lvl_r != $past(lvl_r))
		else $error("no closing edge");
	chk_no_tx_on_rx: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) $rose(tx_busy_out) |-> !$past(rx_busy_out))
		else $error("transmit started while line busy");
endmodule

// ==== rtl/pdbmc_pkg.sv ====
// Package for the baseband biphase mark codec: timing defaults and encodings.
// Assumes a single 250 MHz core clock with synchronous reset.
package pdbmc_pkg;
	localparam int unsigned CLK_MHZ = 250;
	// Nominal unit interval in ns (300 kbps class link)
	localparam int unsigned UI_NS = 3334;
	localparam int unsigned HALF_CYC = (UI_NS * CLK_MHZ) / (2 * 1000);
	localparam int unsigned CNT_W = 12;
	localparam logic [CNT_W-1:0] HALF_DEF = CNT_W'(HALF_CYC);
	// Receive idle timeout in half bits
	localparam logic [CNT_W-1:0] RX_IDLE_HALVES = 12'h0006;
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h0001;
	localparam logic [1:0] EDGE_SEEN_TWO = 2'h2;
	typedef enum logic [1:0] {
		PDBMC_TX_IDLE = 2'b00,
		PDBMC_TX_PRE = 2'b01,
		PDBMC_TX_BIT = 2'b10,
		PDBMC_TX_CLOSE = 2'b11
	} pdbmc_tx_state_t;
endpackage

// ==== rtl/pdbmc_rx.sv ====
// Receive half of the codec: measures intervals between line edges.
// Assumes the line input is already synchronised to ref_clk_in.
`timescale 1ns/1ns
module pdbmc_rx #(
	parameter int unsigned CNT_W = pdbmc_pkg::CNT_W
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic line_in,
	input wire logic enable_in,
	input wire logic [CNT_W-1:0] half_cycles_in,
	output logic bit_valid_out,
	output logic bit_out,
	output logic busy_out
);
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic line_d_r, line_d_nxt;
	logic half_pend_r, half_pend_nxt;
	logic [1:0] edges_r, edges_nxt;
	logic bv_r, bv_nxt, b_r, b_nxt, busy_r, busy_nxt;
	logic [CNT_W:0] thr;
	logic [CNT_W+2:0] idle_lim;
	logic edge_w;

	// Three quarter bit threshold is one and a half half-bits; one extra bit keeps the carry
	assign thr = (CNT_W+1)'({1'b0, half_cycles_in} + {2'b00, half_cycles_in[CNT_W-1:1]});
	assign idle_lim = (CNT_W+3)'((CNT_W+3)'(half_cycles_in)
		* (CNT_W+3)'(pdbmc_pkg::RX_IDLE_HALVES));
	assign edge_w = line_in ^ line_d_r;

	always_comb begin
		cnt_nxt = cnt_r;
		line_d_nxt = line_in;
		half_pend_nxt = half_pend_r;
		edges_nxt = edges_r;
		bv_nxt = 1'b0;
		b_nxt = b_r;
		busy_nxt = busy_r;
		if (!enable_in) begin
			cnt_nxt = pdbmc_pkg::CNT_ZERO;
			half_pend_nxt = 1'b0;
			edges_nxt = 2'h0;
			busy_nxt = 1'b0;
		end else if (edge_w) begin
			cnt_nxt = pdbmc_pkg::CNT_ONE;
			busy_nxt = 1'b1;
			// First edges only lock timing; a missed first edge loses the first data bit
			if (edges_r != pdbmc_pkg::EDGE_SEEN_TWO) begin
				edges_nxt = 2'(edges_r + 2'h1);
			end else if (cnt_r < thr) begin
				if (half_pend_r) begin
					bv_nxt = 1'b1;
					b_nxt = 1'b1;
					half_pend_nxt = 1'b0;
				end else begin
					half_pend_nxt = 1'b1;
				end
			end else begin
				bv_nxt = 1'b1;
				b_nxt = 1'b0;
				half_pend_nxt = 1'b0;
			end
		end else if ((CNT_W+3)'(cnt_r) >= idle_lim || &cnt_r) begin
			// A saturated counter also means idle, so long half bits cannot wrap it
			busy_nxt = 1'b0;
			edges_nxt = 2'h0;
			half_pend_nxt = 1'b0;
		end else begin
			cnt_nxt = CNT_W'(cnt_r + pdbmc_pkg::CNT_ONE);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cnt_r <= pdbmc_pkg::CNT_ZERO;
			// Idle line sits at its bias level, so no false edge follows reset
			line_d_r <= 1'b1;
			half_pend_r <= 1'b0;
			edges_r <= 2'h0;
			bv_r <= 1'b0;
			b_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			line_d_r <= line_d_nxt;
			half_pend_r <= half_pend_nxt;
			edges_r <= edges_nxt;
			bv_r <= bv_nxt;
			b_r <= b_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign bit_valid_out = bv_r;
	assign bit_out = b_r;
	assign busy_out = busy_r;

	chk_zero_full_gap: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) bv_r && !b_r |-> $past(cnt_r) >= $past(thr))
		else $error("zero decoded from short interval");
	chk_one_needs_pair: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) bv_r && b_r |-> $past(half_pend_r))
		else $error("one decoded without prior half bit");
endmodule

// ==== verif/pdbmc_partner_model.sv ====
// Far-side party model: sends biphase mark frames on the shared line.
// Assumes the bench resolves the wire and picks the pin by orientation.
`timescale 1ns/1ns
module pdbmc_partner_model (
	input wire logic ref_clk_in,
	input wire logic line_busy_in,
	output logic drv_oe_out,
	output logic drv_lvl_out
);
	initial begin
		drv_oe_out = 1'b0;
		drv_lvl_out = 1'b1;
	end
	// Drop starts at the idle level, so the first preamble edge never appears
	task automatic send(input logic [31:0] bits, input int n, input int h, input logic drop);
		while (line_busy_in !== 1'b0) @(posedge ref_clk_in);
		@(posedge ref_clk_in);
		drv_oe_out <= 1'b1;
		drv_lvl_out <= drop;
		for (int i = 0; i <= n; i++) begin
			repeat (h) @(posedge ref_clk_in);
			drv_lvl_out <= ~drv_lvl_out;
			if (i == n) break;
			repeat (h) @(posedge ref_clk_in);
			if (bits[i]) drv_lvl_out <= ~drv_lvl_out;
		end
		repeat (h) @(posedge ref_clk_in);
		drv_oe_out <= 1'b0;
	endtask
endmodule

// ==== verif/tb_top.sv ====
// Bench: drives the codec, resolves both pins, decodes the wire, checks the receiver.
// Assumes a pull-up bias on each pin and the far-side model pdbmc_partner_model.
`timescale 1ns/1ns
module tb_top;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic orient_b_in = 1'b0;
	logic tx_start_in = 1'b0;
	logic tx_bit_in = 1'b0;
	logic tx_last_in = 1'b0;
	logic [pdbmc_pkg::CNT_W-1:0] half_cycles_in = 12'h0008;
	logic a_o, a_oe, b_o, b_oe, req, busy, rxv, rxb, rxbusy, p_oe, p_lvl;
	logic prev, half, first;
	logic act = 1'b0;
	logic exp_q[$];
	logic rx_q[$];
	int err_total = 0;
	int n_checks = 0;
	int cnt = 0;
	int h_exp = 8;
	wire line_a = a_oe ? a_o : (p_oe && !orient_b_in) ? p_lvl : 1'b1;
	wire line_b = b_oe ? b_o : (p_oe && orient_b_in) ? p_lvl : 1'b1;
	wire sel_oe = orient_b_in ? b_oe : a_oe;
	wire sel_o = orient_b_in ? b_o : a_o;
	wire oth_oe = orient_b_in ? a_oe : b_oe;
	pdbmc_codec dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.half_cycles_in(half_cycles_in), .orient_b_in(orient_b_in), .tx_start_in(tx_start_in),
		.tx_bit_in(tx_bit_in), .tx_last_in(tx_last_in), .tx_bit_req_out(req), .tx_busy_out(busy),
		.config_channel_pin_a_in(line_a), .config_channel_pin_a_out(a_o),
		.config_channel_pin_a_oe_out(a_oe), .config_channel_pin_b_in(line_b),
		.config_channel_pin_b_out(b_o), .config_channel_pin_b_oe_out(b_oe),
		.rx_bit_valid_out(rxv), .rx_bit_out(rxb), .rx_busy_out(rxbusy));
	pdbmc_partner_model partner (.ref_clk_in(ref_clk_in), .line_busy_in(busy),
		.drv_oe_out(p_oe), .drv_lvl_out(p_lvl));
	initial forever #2 ref_clk_in = ~ref_clk_in;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic pop_cmp(input logic [31:0] seen);
		if (exp_q.size() == 0) chk(seen, 32'hffff_ffff);
		else chk(seen, 32'(exp_q.pop_front()));
	endtask
	task automatic final_report;
		$display("mismatches %0d checks %0d", err_total, n_checks);
		if (err_total == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Each bit is held from before its request until two edges after it
	task automatic tx_pkt(input logic [31:0] bits, input int n, input logic ob,
		input logic [11:0] hc);
		h_exp = (hc == 12'h0000) ? int'(pdbmc_pkg::HALF_DEF) : int'(hc);
		orient_b_in <= ob;
		half_cycles_in <= hc;
		tx_bit_in <= bits[0];
		tx_last_in <= (n == 1);
		tx_start_in <= 1'b1;
		@(posedge ref_clk_in);
		tx_start_in <= 1'b0;
		for (int i = 1; i <= n; i++) begin
			do @(negedge ref_clk_in); while (req !== 1'b1);
			exp_q.push_back(bits[i-1]);
			repeat (2) @(posedge ref_clk_in);
			tx_bit_in <= bits[i];
			tx_last_in <= (i == n - 1);
		end
		do @(negedge ref_clk_in); while (busy !== 1'b0 || rxbusy !== 1'b0);
		chk(32'(exp_q.size()), ZERO);
		@(posedge ref_clk_in);
	endtask
	task automatic rx_pkt(input logic [31:0] bits, input logic drop);
		orient_b_in <= drop;
		half_cycles_in <= 12'h0008;
		rx_q.delete();
		@(posedge ref_clk_in);
		fork
			partner.send(bits, 16, 8, drop);
			begin
				repeat (40) @(posedge ref_clk_in);
				tx_start_in <= 1'b1;
				@(posedge ref_clk_in);
				tx_start_in <= 1'b0;
				repeat (2) @(negedge ref_clk_in);
				chk(32'(busy | a_oe | b_oe), ZERO);
			end
		join
		repeat (70) @(posedge ref_clk_in);
		chk(32'(rxbusy), ZERO);
		chk(32'(rx_q.size() + 2 >= 16), ONE);
		foreach (rx_q[j]) chk(32'(rx_q[j]), 32'(bits[16 - rx_q.size() + j]));
	endtask
	// Wire decoder: interval since the previous edge decides half or full bit
	always @(negedge ref_clk_in) begin
		cnt <= cnt + 1;
		if (rxv === 1'b1) rx_q.push_back(rxb);
		if (sel_oe !== 1'b1) begin
			if (act) chk(cnt, h_exp);
			act <= 1'b0;
		end else if (!act) begin
			chk(32'(sel_o), ZERO);
			{act, prev, first, half} <= 4'ha;
			cnt <= 1;
		end else begin
			chk(32'(oth_oe), ZERO);
			if (sel_o !== prev) begin
				prev <= sel_o;
				cnt <= 1;
				first <= 1'b0;
				if (first) chk(cnt, h_exp);
				else if (cnt > h_exp * 3 / 2) begin
					chk(cnt, 2 * h_exp);
					chk(32'(half), ZERO);
					pop_cmp(ZERO);
				end else begin
					chk(cnt, h_exp);
					if (half) pop_cmp(ONE);
					half <= ~half;
				end
			end
		end
	end
	initial begin
		repeat (30000) @(posedge ref_clk_in);
		err_total++;
		final_report();
	end
	initial begin
		void'($urandom(61));
		repeat (4) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		for (int k = 0; k < 4; k++) tx_pkt($urandom, 4 + 4 * k, k[0], 12'(8 + k));
		tx_pkt($urandom, 3, 1'b0, 12'h0000);
		for (int k = 0; k < 2; k++) rx_pkt($urandom, k[0]);
		final_report();
	end
endmodule
